//--- hdl/dmd_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "dmd_map.svh"
module dmd_top
  import dmd_pkg::*;
#(
  parameter int CNT_W = 4
)
(
  input  wire logic        clock,
  input  wire logic        sys_rst,
  input  wire logic        vcoTick,
  input  wire logic        refClk,
  input  wire logic [3:0]  mainPreset,
  input  wire logic [3:0]  prescalePreset,
  input  wire logic [15:0] loopAmpMv,
  output logic             presOut,
  output logic             terminalCountPulse_n,
  output logic             divOut,
  output logic             modulusCtrlA,
  output logic             modulusCtrlB,
  output logic             pumpUp,
  output logic             pumpDown_n,
  output logic             fastLockEn_n
);
  // Counter type and zero detect are fixed at four bits
  if (CNT_W != 4)
  begin : gBadWidth
    $error("dmd_top supports only 4-bit counters");
  end

  // One counter step; load wins over count, held when disabled
  function automatic dmd_cnt_t cntStep(input dmd_cnt_t cnt,
                                       input dmd_cnt_t preset,
                                       input logic     load_n,
                                       input logic     en_n);
    if (!load_n)
      cntStep = preset;
    else if (!en_n)
      cntStep = cnt - 4'h1;
    else
      cntStep = cnt;
  endfunction

  dmd_pres_t presCnt_q;
  dmd_pres_t presCnt_d;
  logic      presOut_q;
  logic      presOut_d;
  dmd_cnt_t  psCnt_q;
  dmd_cnt_t  psCnt_d;
  dmd_cnt_t  mainCnt_q;
  dmd_cnt_t  mainCnt_d;
  logic      reclock_q;
  logic      reclock_d;
  logic      refPrev_q;
  logic      refPrev_d;
  logic      divPrev_q;
  logic      divPrev_d;
  logic      fastLock_q;
  logic      fastLock_d;
  logic      presTick;
  logic      zeroDetect;
  logic      tcPulse_n;
  dmd_mod_e  mode;
  dmd_pres_t modulus;

  dmd_pfd_if pfdBus ();

  dmd_pfd u_pfd (
    .clock   (clock),
    .sys_rst (sys_rst),
    .pfdBus  (pfdBus.pfd)
  );

  // Enables of the control counter are both the zero-detect output
  assign zeroDetect   = ~(psCnt_q[3] | psCnt_q[2] | psCnt_q[1]);
  assign modulusCtrlA = zeroDetect;
  assign modulusCtrlB = zeroDetect;
  assign mode         = (modulusCtrlA || modulusCtrlB) ? DMD_DIV5 : DMD_DIV6;
  assign modulus      = (mode == DMD_DIV5) ? `DMD_MOD_LOW
                                           : `DMD_MOD_HIGH;
  assign presTick     = vcoTick && (presCnt_q == modulus - 3'h1);
  assign tcPulse_n    = (mainCnt_q != `DMD_CNT_RST);

  always_comb
  begin
    presCnt_d = presCnt_q;
    presOut_d = presTick;
    if (vcoTick)
    begin
      if (presTick)
        presCnt_d = `DMD_PRES_RST;
      else
        presCnt_d = presCnt_q + 3'h1;
    end
  end

  // Counters and reclock flop all move on the prescaler output tick
  always_comb
  begin
    psCnt_d   = psCnt_q;
    mainCnt_d = mainCnt_q;
    reclock_d = reclock_q;
    if (presTick)
    begin
      psCnt_d   = cntStep(psCnt_q, prescalePreset,
                          tcPulse_n, zeroDetect);
      mainCnt_d = cntStep(mainCnt_q, mainPreset,
                          tcPulse_n, 1'b0);
      reclock_d = tcPulse_n;
    end
  end

  // Presets are sampled only at load; mid-cycle changes are not guarded
  // Edges are seen in the clock they arrive; only their spacing matters to the detector
  always_comb
  begin
    refPrev_d    = refClk;
    divPrev_d    = reclock_q;
    pfdBus.refEdge = refClk && !refPrev_q;
    pfdBus.divEdge = reclock_q && !divPrev_q;
  end

  // Strict limits: the threshold values themselves count as in range
  always_comb
  begin
    fastLock_d = 1'b1;
    if (loopAmpMv > `DMD_FAST_HI_MV || loopAmpMv < `DMD_FAST_LO_MV)
      fastLock_d = 1'b0;
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      presCnt_q  <= `DMD_PRES_RST;
      presOut_q  <= 1'b0;
      psCnt_q    <= `DMD_CNT_RST;
      mainCnt_q  <= `DMD_CNT_RST;
      reclock_q  <= 1'b0;
      refPrev_q  <= 1'b0;
      divPrev_q  <= 1'b0;
      fastLock_q <= 1'b1;
    end
    else
    begin
      presCnt_q  <= presCnt_d;
      presOut_q  <= presOut_d;
      psCnt_q    <= psCnt_d;
      mainCnt_q  <= mainCnt_d;
      reclock_q  <= reclock_d;
      refPrev_q  <= refPrev_d;
      divPrev_q  <= divPrev_d;
      fastLock_q <= fastLock_d;
    end
  end

  assign presOut              = presOut_q;
  assign terminalCountPulse_n = tcPulse_n;
  assign divOut               = reclock_q;
  assign pumpUp               = ~pfdBus.refQ;
  assign pumpDown_n           = pfdBus.divQ;
  assign fastLockEn_n         = fastLock_q;

  AST_PRES_RANGE: assert property (
    @(posedge clock) disable iff (sys_rst)
    presCnt_q < `DMD_MOD_HIGH)
    else $error("prescaler count out of range");
  AST_PRES_WRAP: assert property (
    @(posedge clock) disable iff (sys_rst)
    presTick |=> presOut_q && presCnt_q == `DMD_PRES_RST)
    else $error("prescaler did not wrap on its output tick");
  AST_DIV6_WHILE_UPPER: assert property (
    @(posedge clock) disable iff (sys_rst)
    (|psCnt_q[3:1]) |-> (modulus == `DMD_MOD_HIGH && !modulusCtrlA))
    else $error("divide by 6 not selected");
  AST_DIV5_AT_ONE: assert property (
    @(posedge clock) disable iff (sys_rst)
    presTick && tcPulse_n && psCnt_q == 4'h2
      |=> zeroDetect && modulus == `DMD_MOD_LOW)
    else $error("divide by 5 not selected at count 1");
  AST_ZERO_HOLDS: assert property (
    @(posedge clock) disable iff (sys_rst)
    zeroDetect && !(presTick && !tcPulse_n) |=> $stable(psCnt_q))
    else $error("control counter moved while disabled");
  AST_DIV5_PERSIST: assert property (
    @(posedge clock) disable iff (sys_rst)
    zeroDetect && !(presTick && !tcPulse_n)
      |=> zeroDetect && modulus == `DMD_MOD_LOW)
    else $error("divide by 5 dropped before load");
  AST_LOAD_RESTART: assert property (
    @(posedge clock) disable iff (sys_rst)
    presTick && !tcPulse_n && prescalePreset[3:1] != 3'h0
      |=> !zeroDetect && modulus == `DMD_MOD_HIGH)
    else $error("load did not restart divide by 6");
  AST_CTRL_COUNTS: assert property (
    @(posedge clock) disable iff (sys_rst)
    presTick && tcPulse_n && !zeroDetect
      |=> psCnt_q == $past(psCnt_q) - 4'h1)
    else $error("control counter did not count");
  AST_MAIN_COUNTS: assert property (
    @(posedge clock) disable iff (sys_rst)
    presTick && tcPulse_n |=> mainCnt_q == $past(mainCnt_q) - 4'h1)
    else $error("main counter did not count");
  AST_TC_AT_ZERO: assert property (
    @(posedge clock) disable iff (sys_rst)
    presTick && tcPulse_n && mainCnt_q == 4'h1 |=> !terminalCountPulse_n)
    else $error("terminal count missing at zero");
  AST_TC_ONE_PERIOD: assert property (
    @(posedge clock) disable iff (sys_rst)
    presTick && !tcPulse_n && mainPreset != 4'h0 |=> terminalCountPulse_n)
    else $error("terminal count outlived its load");
  AST_LOAD_BOTH: assert property (
    @(posedge clock) disable iff (sys_rst)
    presTick && !tcPulse_n |=> mainCnt_q == $past(mainPreset)
      && psCnt_q == $past(prescalePreset) && !divOut)
    else $error("load did not preset both counters");
  AST_RECLOCK: assert property (
    @(posedge clock) disable iff (sys_rst)
    presTick |=> divOut == $past(tcPulse_n))
    else $error("reclock flop missed the terminal count");
  AST_FAST_LOCK: assert property (
    @(posedge clock) disable iff (sys_rst)
    (loopAmpMv > `DMD_FAST_HI_MV || loopAmpMv < `DMD_FAST_LO_MV)
      |=> !fastLockEn_n)
    else $error("fast lock not enabled out of range");
  AST_FAST_IDLE: assert property (
    @(posedge clock) disable iff (sys_rst)
    (loopAmpMv <= `DMD_FAST_HI_MV && loopAmpMv >= `DMD_FAST_LO_MV)
      |=> fastLockEn_n)
    else $error("fast lock enabled in range");
endmodule
`default_nettype wire

//--- hdl/dmd_map.svh
// What this block does
// - Prescaler divides its input by 5 or 6 as its modulus controls select.
// - Prescale control counter counts only with both enables low; low load presets it.
// - Control counter counts down from preset; upper bits nonzero keep divide by 6.
// - At count 1 zero-detect goes high, stops counter, selects divide by 5.
// - Divide by 5 holds until the next load pulse restarts the sequence.
// - Main down counter is always enabled, counting down each prescaler tick.
// - Main counter gives an active-low terminal-count pulse at count zero.
// - Terminal count loads both counters and feeds the reclock flop.
// - Detector has two flops with data low; reference and divider clock them.
// - Each rising clock edge drives that detector flop's true output low.
// - Both detector outputs low makes the reset NOR high, resetting both flops.
// - Divider fast gives wide low divider pulses, narrow reference pulses.
// - Divider slow gives wide high reference pulses, narrow divider pulses.
// - In lock reference and divider pulses are equal, each one clock wide.
// - Fast-lock enable goes low above +18 V or below +1.6 V, else high.
`ifndef DMD_MAP_SVH
`define DMD_MAP_SVH

`define DMD_MOD_LOW      3'h5
`define DMD_MOD_HIGH     3'h6
`define DMD_PRES_RST     3'h0
`define DMD_CNT_RST      4'h0
`define DMD_FAST_HI_MV   16'h4650
`define DMD_FAST_LO_MV   16'h0640
`define DMD_REF_FREQ_MHZ 1

`endif

//--- hdl/dmd_pkg.sv
package dmd_pkg;
  typedef logic [3:0] dmd_cnt_t;
  typedef logic [2:0] dmd_pres_t;
  typedef enum logic {DMD_DIV6, DMD_DIV5} dmd_mod_e;
endpackage

//--- hdl/dmd_pfd_if.sv
`timescale 1ns/1ps
`default_nettype none
interface dmd_pfd_if;
  logic refEdge;
  logic divEdge;
  logic refQ;
  logic divQ;
  logic resetNor;
  modport ctrl (output refEdge, output divEdge,
                input refQ, input divQ, input resetNor);
  modport pfd  (input refEdge, input divEdge,
                output refQ, output divQ, output resetNor);
endinterface
`default_nettype wire

//--- hdl/dmd_pfd.sv
`timescale 1ns/1ps
`default_nettype none
module dmd_pfd
  import dmd_pkg::*;
(
  input  wire logic clock,
  input  wire logic sys_rst,
  dmd_pfd_if.pfd    pfdBus
);
  logic refQ_q;
  logic refQ_d;
  logic divQ_q;
  logic divQ_d;

  assign pfdBus.refQ     = refQ_q;
  assign pfdBus.divQ     = divQ_q;
  assign pfdBus.resetNor = ~(refQ_q | divQ_q);

  // Reset from the NOR wins over a coincident edge, as a direct clear would
  always_comb
  begin
    refQ_d = refQ_q;
    divQ_d = divQ_q;
    if (pfdBus.resetNor)
    begin
      refQ_d = 1'b1;
      divQ_d = 1'b1;
    end
    else
    begin
      if (pfdBus.refEdge)
        refQ_d = 1'b0;
      if (pfdBus.divEdge)
        divQ_d = 1'b0;
    end
  end

  // Pulse widths follow edge spacing
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      refQ_q <= 1'b1;
      divQ_q <= 1'b1;
    end
    else
    begin
      refQ_q <= refQ_d;
      divQ_q <= divQ_d;
    end
  end

  AST_REF_EDGE_LOW: assert property (
    @(posedge clock) disable iff (sys_rst)
    pfdBus.refEdge && refQ_q |=> !refQ_q)
    else $error("reference flop did not go low");
  AST_NOR_RESETS: assert property (
    @(posedge clock) disable iff (sys_rst)
    (!refQ_q && !divQ_q) |=> (refQ_q && divQ_q))
    else $error("detector flops not reset by NOR");
  AST_DIV_EDGE_LOW: assert property (
    @(posedge clock) disable iff (sys_rst)
    pfdBus.divEdge && divQ_q |=> !divQ_q)
    else $error("divider flop did not go low");
  AST_DIV_NARROW: assert property (
    @(posedge clock) disable iff (sys_rst)
    pfdBus.divEdge && divQ_q && !refQ_q |=> !divQ_q ##1 (divQ_q && refQ_q))
    else $error("divider pulse not narrow while reference leads");
endmodule
`default_nettype wire

//--- dv/dmd_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
module dmd_ctrl_model
(
  input  wire logic       clock,
  input  wire logic       sys_rst,
  input  wire logic       presOut,
  input  wire logic       divOut,
  input  wire logic [3:0] reqMain,
  input  wire logic [3:0] reqPres,
  output logic      [3:0] mainPreset,
  output logic      [3:0] prescalePreset
);
  // Update only just after a load, so presets stand for a whole division cycle
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      mainPreset     <= 4'h0;
      prescalePreset <= 4'h0;
    end
    else if (presOut && !divOut)
    begin
      mainPreset     <= reqMain;
      prescalePreset <= reqPres;
    end
  end
endmodule
`default_nettype wire

//--- dv/test_dmd_top.sv
`timescale 1ns/1ps
`default_nettype none
module test_dmd_top;
  typedef struct {int ticks; int pres;} dmd_note_s;
  logic        clock = 1'b0;
  logic        sys_rst = 1'b1;
  logic        vcoTick = 1'b0;
  logic        refClk = 1'b0;
  logic        tickRun = 1'b0;
  logic        tcPrev = 1'b0;
  logic [3:0]  reqMain = 4'h0;
  logic [3:0]  reqPres = 4'h0;
  logic [3:0]  mainPreset;
  logic [3:0]  prescalePreset;
  logic [15:0] loopAmpMv = 16'h2328;
  logic [31:0] rs = 32'h0000004d;
  logic        presOut, tcN, divOut, modA, modB;
  logic        pumpUp, pumpDown_n, fastLockEn_n;
  int          mismatches = 0, check_count = 0;
  int          fallCnt = 0, tickCnt = 0, presCnt = 0;
  dmd_note_s   notes[$];
  dmd_note_s   n;
  logic [15:0] amp [5] = '{16'h4650, 16'h4651, 16'h0640, 16'h063f, 16'h2328};
  logic [0:4]  fle = 5'b10101;

  dmd_top dmd_top_inst (.clock(clock), .sys_rst(sys_rst),
    .vcoTick(vcoTick), .refClk(refClk), .mainPreset(mainPreset),
    .prescalePreset(prescalePreset), .loopAmpMv(loopAmpMv),
    .presOut(presOut), .terminalCountPulse_n(tcN), .divOut(divOut),
    .modulusCtrlA(modA), .modulusCtrlB(modB), .pumpUp(pumpUp),
    .pumpDown_n(pumpDown_n), .fastLockEn_n(fastLockEn_n));
  dmd_ctrl_model dmd_ctrl_model_inst (.clock(clock), .sys_rst(sys_rst),
    .presOut(presOut), .divOut(divOut), .reqMain(reqMain),
    .reqPres(reqPres),
    .mainPreset(mainPreset), .prescalePreset(prescalePreset));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic step(input int k);
    repeat (k) @(posedge clock);
    #1;
  endtask

  // Presets reach the counters only at the second load after a request
  task automatic run_div(input int m, input int p);
    int s;
    step(1);
    reqMain = 4'(m);
    reqPres = 4'(p);
    s = fallCnt;
    wait (fallCnt == s + 2);
    repeat (2) notes.push_back('{5 * (m + 1) + (p > 0 ? p - 1 : 0), m + 1});
    wait (fallCnt == s + 4);
  endtask

  initial
  begin
    forever #4 clock = ~clock;
  end

  // Random gaps, back to back ticks included
  always @(posedge clock)
  begin
    #1;
    rs = xs(rs);
    vcoTick = tickRun & (rs[0] | rs[1]);
  end

  always @(negedge clock)
  begin
    presCnt += int'(presOut === 1'b1);
    if (tcPrev === 1'b1 && tcN === 1'b0)
    begin
      if (notes.size() > 0)
      begin
        n = notes.pop_front();
        check(16'(tickCnt), 16'(n.ticks));
        check(16'(presCnt), 16'(n.pres));
        check(divOut, 16'h0001);
      end
      fallCnt++;
      tickCnt = 0;
      presCnt = 0;
    end
    tickCnt += int'(vcoTick === 1'b1);
    tcPrev = tcN;
  end

  initial
  begin
    #400000;
    mismatches++;
    final_report();
  end

  initial
  begin : main
    int m, p, k;
    step(10);
    sys_rst = 1'b0;
    @(negedge clock);
    check(tcN, 16'h0000);
    check(modA, 16'h0001);
    check(modB, 16'h0001);
    tickRun = 1'b1;
    // A zero main preset would hold the terminal count low for good
    run_div(1, 2);
    run_div(15, 0);
    run_div(15, 15);
    run_div(4, 5);
    for (int i = 0; i < 4; i++)
    begin
      rs = xs(rs);
      m = 3 + rs[7:0] % 12;
      p = 1 + rs[15:8] % (m + 1);
      run_div(m, p);
    end
    tickRun = 1'b0;
    step(20);
    // First reference edge clears a divider-side low left by the ratio runs
    refClk = 1'b1;
    step(4);
    refClk = 1'b0;
    step(4);
    refClk = 1'b1;
    step(40);
    check(pumpUp, 16'h0001);
    check(pumpDown_n, 16'h0001);
    tickRun = 1'b1;
    for (k = 0; k < 2000 && pumpUp !== 1'b0; k++)
      step(1);
    step(2);
    check(pumpUp, 16'h0000);
    check(pumpDown_n, 16'h0001);
    refClk = 1'b0;
    step(600);
    check(pumpDown_n, 16'h0000);
    check(pumpUp, 16'h0000);
    tickRun = 1'b0;
    step(10);
    refClk = 1'b1;
    step(5);
    check(pumpUp, 16'h0000);
    check(pumpDown_n, 16'h0001);
    foreach (amp[i])
    begin
      loopAmpMv = amp[i];
      step(2);
      check(fastLockEn_n, 16'(fle[i]));
    end
    final_report();
  end
endmodule
`default_nettype wire
